// File: pic_ctrl.sv
// Prioritized vectored interrupt controller with low-power and reset control
// Assumes the core acknowledges vectors and executes the opcodes it reports
`default_nettype none
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_DEPTH_DEF,
  parameter int STAT_W = STAT_W_DEF,
  parameter int PD_XTAL_CYCLES = PD_XTAL_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  // Level input, edge when edge_ext_b is set; shares a pin with programmable_flag_pins_upper
  input wire logic ext_int_b,
  input wire logic level_int_0,
  input wire logic level_int_1,
  input wire logic edge_int,
  input wire logic serial1_is_flags,
  input wire logic ext_int_a0,
  input wire logic ext_int_a1,
  input wire logic flag_input,
  output logic flag_input_val,
  input wire logic flag_out_wr,
  input wire logic flag_out_wdata,
  output logic flag_output,
  input wire logic serial0_tx_evt,
  input wire logic serial0_rx_evt,
  input wire logic serial1_tx_evt,
  input wire logic serial1_rx_evt,
  input wire logic byte_dma_evt,
  input wire logic timer_evt,
  input wire logic powerdown_request_pin,
  output logic powerdown_ack_pin,
  input wire logic pd_enter_op,
  input wire logic osc_stopped,
  input wire logic powerup_context_reset_bit,
  input wire logic mask_wr,
  input wire logic [NSRC-1:0] mask_wdata,
  output logic [NSRC-1:0] interrupt_mask_reg,
  input wire logic ctrl_wr,
  input wire pic_ctrl_t ctrl_wdata,
  output pic_ctrl_t interrupt_control_reg,
  input wire logic fc_wr,
  input wire pic_fc_t fc_wdata,
  input wire logic global_int_enable_op,
  input wire logic global_int_disable_op,
  output logic int_enabled,
  output logic int_req,
  output logic [VEC_W-1:0] int_vector,
  output logic [SRC_W-1:0] int_src,
  input wire logic int_ack,
  input wire logic int_rti,
  input wire logic loop_push,
  input wire logic loop_pop,
  input wire logic [STAT_W-1:0] status_in,
  output logic [STAT_W-1:0] status_out,
  output logic stack_overflow,
  output logic stack_underflow,
  input wire logic ms_wr,
  input wire logic [MODE_STATUS_REG_W-1:0] ms_wdata,
  output logic [MODE_STATUS_REG_W-1:0] mode_status_reg,
  input wire logic idle_op,
  input wire logic slow_idle_en,
  input wire logic [1:0] slow_div_sel,
  output logic core_idle,
  output logic core_tick,
  input wire logic boot_cfg,
  input wire logic bus_req_pending,
  input wire logic boot_done,
  output logic boot_start,
  output logic core_restart,
  output logic core_resume,
  output logic [VEC_W-1:0] restart_vector
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  if (STACK_DEPTH < 1 || STACK_DEPTH > 255) begin : g_chk_stack
    $error("STACK_DEPTH out of range");
  end
  if (PD_XTAL_CYCLES < 1 || PD_XTAL_CYCLES >= (1 << REC_W)) begin : g_chk_rec
    $error("PD_XTAL_CYCLES does not fit the recovery counter");
  end

  function automatic pic_sel_t pri_enc(input logic [NSRC-1:0] v);
    pic_sel_t s;
    s = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        s.valid = 1'b1;
        s.idx = SRC_W'(i);
      end
    end
    return s;
  endfunction

  logic [NSRC-1:0] raw_prev_ff, latch_ff, mask_ff, in_svc_ff;
  pic_ctrl_t ctrl_ff;
  logic gie_ff, int_req_ff;
  logic [VEC_W-1:0] vec_ff;
  logic [SRC_W-1:0] src_ff;
  pic_pd_t pd_st_ff, nxt_pd_st;
  pic_boot_t bt_st_ff, nxt_bt_st;
  logic [REC_W-1:0] rec_cnt_ff, nxt_rec_cnt;
  logic idle_ff, slow_ff;
  logic [1:0] div_sel_ff;
  logic [DIV_W-1:0] div_cnt_ff;
  logic [STAT_W-1:0] stk_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic [STAT_W-1:0] status_ff;
  logic ovf_ff, unf_ff, restart_ff, resume_ff, boot_start_ff;
  logic [MODE_STATUS_REG_W-1:0] ms_ff;
  logic flag_in_ff, flag_out_ff;

  // Request sources in priority order
  wire logic [NSRC-1:0] raw;
  assign raw[SRC_PD] = powerdown_request_pin;
  assign raw[SRC_EXT_B] = ext_int_b;
  assign raw[SRC_L1] = level_int_1;
  assign raw[SRC_L0] = level_int_0;
  assign raw[SRC_S0TX] = serial0_tx_evt;
  assign raw[SRC_S0RX] = serial0_rx_evt;
  assign raw[SRC_EDGE] = edge_int;
  assign raw[SRC_BYTE_DMA] = byte_dma_evt;
  assign raw[SRC_S1TX] = serial1_is_flags ? ext_int_a1 : serial1_tx_evt;
  assign raw[SRC_S1RX] = serial1_is_flags ? ext_int_a0 : serial1_rx_evt;
  assign raw[SRC_TIMER] = timer_evt;

  // Internal events are always latched on their rising edge
  wire logic edge_a1 = !serial1_is_flags || ctrl_ff.edge_a1;
  wire logic edge_a0 = !serial1_is_flags || ctrl_ff.edge_a0;
  wire logic [NSRC-1:0] is_edge = {1'b1, edge_a0, edge_a1, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b0, 1'b0, ctrl_ff.edge_ext_b, 1'b1};

  wire logic [NSRC-1:0] rise = raw & ~raw_prev_ff;
  // While asleep the pin edge is a wake-up, not a new request
  wire logic [NSRC-1:0] pd_gate = (pd_st_ff == PD_RUN) ? '1 : ~MASK_NMI;
  wire logic [NSRC-1:0] edge_set = rise & is_edge & pd_gate;
  wire logic [NSRC-1:0] fc_set = fc_wr ? fc_wdata.force_bits : '0;
  wire logic [NSRC-1:0] fc_clr = fc_wr ? fc_wdata.clear_bits : '0;
  wire logic ack_take = int_ack && int_req_ff;
  wire logic [NSRC-1:0] one = NSRC'(1);
  wire logic [NSRC-1:0] ack_oh = ack_take ? (one << src_ff) : '0;
  // Set wins over clear so a coincident edge is not lost
  wire logic [NSRC-1:0] nxt_latch =
    (latch_ff & ~(fc_clr | ack_oh)) | edge_set | fc_set;
  wire logic [NSRC-1:0] pending = latch_ff | (raw & ~is_edge);

  wire logic [NSRC-1:0] unmasked = pending & (mask_ff | MASK_NMI);
  wire logic [NSRC-1:0] elig = unmasked & {NSRC{gie_ff}};
  wire pic_sel_t sel = pri_enc(elig);
  wire pic_sel_t top = pri_enc(in_svc_ff);
  wire logic nest_ok = ctrl_ff.nest_en ?
    (!top.valid || sel.idx < top.idx) : !top.valid;
  wire logic can_issue = sel.valid && nest_ok &&
    pd_st_ff == PD_RUN && bt_st_ff == BT_DONE;
  // Only service is held off; DMA and autobuffer paths never see this
  wire logic nxt_int_req = can_issue && !int_ack && !mask_wr &&
    !global_int_disable_op;
  wire logic [NSRC-1:0] rti_oh = (int_rti && top.valid) ?
    (one << top.idx) : '0;
  wire logic [NSRC-1:0] nxt_svc = (in_svc_ff & ~rti_oh) | ack_oh;
  wire logic nxt_gie = global_int_enable_op ? 1'b1 :
    (global_int_disable_op ? 1'b0 : gie_ff);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      raw_prev_ff <= '0;
      latch_ff <= '0;
      mask_ff <= MASK_RST;
      ctrl_ff <= CTRL_RST;
      in_svc_ff <= '0;
      gie_ff <= GIE_RST;
      int_req_ff <= 1'b0;
      vec_ff <= RESET_VEC;
      src_ff <= SRC_PD;
    end else begin
      raw_prev_ff <= raw;
      latch_ff <= nxt_latch;
      mask_ff <= mask_wr ? mask_wdata : mask_ff;
      ctrl_ff <= ctrl_wr ? ctrl_wdata : ctrl_ff;
      in_svc_ff <= nxt_svc;
      gie_ff <= nxt_gie;
      int_req_ff <= nxt_int_req;
      vec_ff <= VEC_TAB[sel.idx];
      src_ff <= sel.idx;
    end
  end

  // Status stack, shared by interrupt service and loop nesting
  wire logic do_push = ack_take || loop_push;
  wire logic do_pop = int_rti || loop_pop;
  wire logic stk_full = sp_ff == SP_W'(STACK_DEPTH);
  wire logic stk_empty = sp_ff == '0;
  wire logic [SP_W-1:0] sp_dec = sp_ff - SP_W'(1);

  always_ff @(posedge ref_clk) begin
    if (do_push && !stk_full) begin
      stk_mem[sp_ff] <= status_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sp_ff <= '0;
      status_ff <= '0;
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
      ms_ff <= MODE_STATUS_REG_RST;
    end else begin
      if (do_push) begin
        sp_ff <= stk_full ? sp_ff : sp_ff + SP_W'(1);
        ovf_ff <= ovf_ff || stk_full;
      end else if (do_pop) begin
        sp_ff <= stk_empty ? sp_ff : sp_dec;
        status_ff <= stk_empty ? status_ff : stk_mem[sp_dec];
        unf_ff <= unf_ff || stk_empty;
      end
      ms_ff <= ms_wr ? ms_wdata : ms_ff;
    end
  end

  // Idle and slow idle; the core advances only on core_tick
  wire logic wake = |unmasked;
  wire logic [DIV_W-1:0] div_last =
    (DIV_W'(SLOW_DIV_MIN) << div_sel_ff) - DIV_W'(1);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      idle_ff <= 1'b0;
      slow_ff <= 1'b0;
      div_sel_ff <= 2'h0;
      div_cnt_ff <= '0;
    end else begin
      idle_ff <= idle_op || (idle_ff && !wake);
      slow_ff <= (idle_op && slow_idle_en) || (slow_ff && !wake);
      div_sel_ff <= idle_op ? slow_div_sel : div_sel_ff;
      div_cnt_ff <= (!slow_ff || div_cnt_ff == div_last) ?
        '0 : div_cnt_ff + DIV_W'(1);
    end
  end

  // Power-down sequencing; reset always returns to run
  wire logic pd_done = pd_st_ff == PD_RECOV && rec_cnt_ff == '0;
  wire logic [REC_W-1:0] rec_load = osc_stopped ?
    REC_W'(PD_XTAL_CYCLES - 1) : REC_W'(PD_FAST_CYC - 1);

  always_comb begin
    nxt_pd_st = pd_st_ff;
    nxt_rec_cnt = rec_cnt_ff;
    case (pd_st_ff)
      PD_RUN: begin
        if (pd_enter_op) begin
          nxt_pd_st = PD_SLEEP;
        end
      end
      PD_SLEEP: begin
        if (rise[SRC_PD]) begin
          nxt_pd_st = PD_RECOV;
          nxt_rec_cnt = rec_load;
        end
      end
      PD_RECOV: begin
        if (pd_done) begin
          nxt_pd_st = PD_RUN;
        end else begin
          nxt_rec_cnt = rec_cnt_ff - REC_W'(1);
        end
      end
      default: nxt_pd_st = PD_RUN;
    endcase
  end

  // Boot and first fetch after reset release
  wire logic bt_go = bt_st_ff == BT_HOLD && !bus_req_pending;
  wire logic bt_boot = bt_go && boot_cfg;
  wire logic bt_fin = (bt_go && !boot_cfg) ||
    (bt_st_ff == BT_LOAD && boot_done);

  always_comb begin
    nxt_bt_st = bt_st_ff;
    case (bt_st_ff)
      BT_HOLD: begin
        if (bt_boot) begin
          nxt_bt_st = BT_LOAD;
        end else if (bt_fin) begin
          nxt_bt_st = BT_DONE;
        end
      end
      BT_LOAD: begin
        if (boot_done) begin
          nxt_bt_st = BT_DONE;
        end
      end
      default: nxt_bt_st = BT_DONE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pd_st_ff <= PD_RUN;
      rec_cnt_ff <= '0;
      bt_st_ff <= BT_HOLD;
      boot_start_ff <= 1'b0;
      restart_ff <= 1'b0;
      resume_ff <= 1'b0;
      flag_in_ff <= 1'b0;
      flag_out_ff <= 1'b0;
    end else begin
      pd_st_ff <= nxt_pd_st;
      rec_cnt_ff <= nxt_rec_cnt;
      bt_st_ff <= nxt_bt_st;
      boot_start_ff <= bt_boot;
      restart_ff <= bt_fin || (pd_done && powerup_context_reset_bit);
      resume_ff <= pd_done && !powerup_context_reset_bit;
      flag_in_ff <= serial1_is_flags && flag_input;
      flag_out_ff <= flag_out_wr ? flag_out_wdata : flag_out_ff;
    end
  end

  assign powerdown_ack_pin = pd_st_ff == PD_SLEEP;
  assign core_tick = !slow_ff || div_cnt_ff == '0;
  assign restart_vector = RESET_VEC;
  assign flag_output = serial1_is_flags && flag_out_ff;
  assign flag_input_val = flag_in_ff;
  assign interrupt_mask_reg = mask_ff;
  assign interrupt_control_reg = ctrl_ff;
  assign int_enabled = gie_ff;
  assign int_req = int_req_ff;
  assign int_vector = vec_ff;
  assign int_src = src_ff;
  assign status_out = status_ff;
  assign stack_overflow = ovf_ff;
  assign stack_underflow = unf_ff;
  assign mode_status_reg = ms_ff;
  assign core_idle = idle_ff;
  assign boot_start = boot_start_ff;
  assign core_restart = restart_ff;
  assign core_resume = resume_ff;

  // Cycles since the acknowledge pin fell, so long waits need no delay
  logic [REC_W-1:0] a_cnt_ff;
  logic a_fast_ff, a_wake_ff;
  always_ff @(posedge ref_clk) begin
    a_cnt_ff <= powerdown_ack_pin ? '0 : a_cnt_ff + REC_W'(1);
    a_fast_ff <= powerdown_ack_pin ? !osc_stopped : a_fast_ff;
    a_wake_ff <= rst_b && (powerdown_ack_pin ||
      (a_wake_ff && !core_restart && !core_resume));
  end
  logic [NSRC-1:0] mask_prev_ff;
  always_ff @(posedge ref_clk) begin
    mask_prev_ff <= mask_ff | MASK_NMI;
  end
  wire logic seq_busy = !ctrl_ff.nest_en && (|in_svc_ff);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_mask_block: assert property (
    mask_wr |=> !int_req)
    else $error("interrupt offered right after mask write");
  a_mask_gate: assert property (
    int_req ##0 $past(rst_b) |-> mask_prev_ff[int_src])
    else $error("masked source offered");
  a_gie_gate: assert property (
    !gie_ff && !global_int_enable_op |=> !int_req)
    else $error("interrupt offered while globally disabled");
  a_seq_hold: assert property (
    seq_busy |=> !int_req)
    else $error("sequential mode preempted a handler");
  a_edge_hold: assert property (
    latch_ff[SRC_EDGE] && !ack_oh[SRC_EDGE] && !fc_clr[SRC_EDGE]
    |=> latch_ff[SRC_EDGE])
    else $error("edge request lost before service");
  a_level_only: assert property (
    !fc_wr |=> !$rose(latch_ff[SRC_L0]))
    else $error("level source latched without force");
  a_pd_ack: assert property (
    $rose(powerdown_ack_pin) |-> $past(pd_enter_op))
    else $error("acknowledge without entering power-down");
  a_pd_fast: assert property (
    a_wake_ff && a_fast_ff && (core_restart || core_resume)
    |-> a_cnt_ff == REC_W'(PD_FAST_CYC))
    else $error("fast wake-up count wrong");
  a_pd_xtal: assert property (
    a_wake_ff && !a_fast_ff && (core_restart || core_resume)
    |-> a_cnt_ff == REC_W'(PD_XTAL_CYCLES))
    else $error("crystal wake-up count wrong");
  a_slow_tick: assert property (
    slow_ff && core_tick ##1 slow_ff |-> !core_tick)
    else $error("slow idle tick too frequent");
  a_boot_fetch: assert property (
    bt_st_ff == BT_LOAD && boot_done |=> core_restart)
    else $error("no fetch after boot load");
  a_reset_state: assert property (disable iff (1'b0)
    !rst_b |=> mask_ff == MASK_RST && sp_ff == '0 && ms_ff == MODE_STATUS_REG_RST)
    else $error("reset state wrong");
  a_gie_reset: assert property (disable iff (1'b0)
    !rst_b |=> gie_ff)
    else $error("global enable not set by reset");

  c_take: cover property (int_req && int_ack);
  c_nested: cover property (ack_take && top.valid);
  c_powerdown: cover property ($fell(powerdown_ack_pin));
  c_slow: cover property (slow_ff && core_tick);
endmodule // pic_ctrl
`default_nettype wire

// File: pic_pkg.sv
// Constants, vectors and carrier types of the interrupt controller
// Assumes one 50 MHz instruction clock and a synchronous active-low reset
`default_nettype none
package pic_pkg;
  localparam int NSRC = 11;
  localparam int SRC_W = 4;
  localparam int VEC_W = 14;
  // Source index equals priority, 0 is the highest
  localparam logic [SRC_W-1:0] SRC_PD = 4'h0;
  localparam logic [SRC_W-1:0] SRC_EXT_B = 4'h1;
  localparam logic [SRC_W-1:0] SRC_L1 = 4'h2;
  localparam logic [SRC_W-1:0] SRC_L0 = 4'h3;
  localparam logic [SRC_W-1:0] SRC_S0TX = 4'h4;
  localparam logic [SRC_W-1:0] SRC_S0RX = 4'h5;
  localparam logic [SRC_W-1:0] SRC_EDGE = 4'h6;
  localparam logic [SRC_W-1:0] SRC_BYTE_DMA = 4'h7;
  localparam logic [SRC_W-1:0] SRC_S1TX = 4'h8;
  localparam logic [SRC_W-1:0] SRC_S1RX = 4'h9;
  localparam logic [SRC_W-1:0] SRC_TIMER = 4'hA;
  localparam logic [VEC_W-1:0] RESET_VEC = 14'h0000;
  localparam logic [VEC_W-1:0] VEC_TAB [NSRC] = '{
    14'h002C, 14'h0004, 14'h0008, 14'h000C, 14'h0010, 14'h0014,
    14'h0018, 14'h001C, 14'h0020, 14'h0024, 14'h0028};
  localparam logic [NSRC-1:0] MASK_RST = 11'h000;
  localparam logic [NSRC-1:0] MASK_NMI = 11'h001;
  localparam logic GIE_RST = 1'b1;
  localparam int MODE_STATUS_REG_W = 7;
  localparam logic [MODE_STATUS_REG_W-1:0] MODE_STATUS_REG_RST = 7'h00;
  // Input clock runs at half the instruction rate
  localparam int REF_CLK_HZ = 50_000_000;
  localparam int INCLK_HZ = 25_000_000;
  localparam int CYC_PER_INCLK = REF_CLK_HZ / INCLK_HZ;
  localparam int PD_FAST_INCLK = 200;
  localparam int PD_XTAL_INCLK = 4096;
  localparam int PD_FAST_CYC = PD_FAST_INCLK * CYC_PER_INCLK;
  localparam int PD_XTAL_CYC = PD_XTAL_INCLK * CYC_PER_INCLK;
  localparam int REC_W = 14;
  localparam int SLOW_DIV_MIN = 16;
  localparam int DIV_W = 8;
  localparam int STACK_DEPTH_DEF = 12;
  localparam int STAT_W_DEF = 16;

  typedef struct packed {
    logic nest_en;
    logic edge_ext_b;
    logic edge_a1;
    logic edge_a0;
  } pic_ctrl_t;
  localparam pic_ctrl_t CTRL_RST = 4'h0;

  typedef struct packed {
    logic [NSRC-1:0] force_bits;
    logic [NSRC-1:0] clear_bits;
  } pic_fc_t;

  typedef struct packed {
    logic valid;
    logic [SRC_W-1:0] idx;
  } pic_sel_t;

  typedef enum logic [1:0] {
    PD_RUN = 2'b00,
    PD_SLEEP = 2'b01,
    PD_RECOV = 2'b10
  } pic_pd_t;

  typedef enum logic [1:0] {
    BT_HOLD = 2'b00,
    BT_LOAD = 2'b01,
    BT_DONE = 2'b10
  } pic_boot_t;
endpackage
`default_nettype wire

// File: pic_src_mdl.sv
// Model of the on-chip event sources and the power-down request pin
// Assumes fire bits are driven just after a rising edge of ref_clk
`default_nettype none
module pic_src_mdl
  import pic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [6:0] fire,
  input wire logic long_pulse,
  output logic [6:0] evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // High cycles left per line; a long pulse must still count only once
  logic [1:0] left_ff [7];
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 7; i++) begin
      if (!rst_b) begin
        left_ff[i] <= 2'h0;
      end else if (fire[i]) begin
        left_ff[i] <= long_pulse ? 2'h3 : 2'h1;
      end else if (left_ff[i] != 2'h0) begin
        left_ff[i] <= left_ff[i] - 2'h1;
      end
    end
  end
  // Push-pull sources, so a released line reads low at once
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      evt[i] = left_ff[i] != 2'h0;
    end
  end
endmodule // pic_src_mdl
`default_nettype wire

// File: test_pic_ctrl.sv
// Self-checking bench of the interrupt controller
// Assumes pic_pkg, pic_ctrl and pic_src_mdl are compiled before it
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  n_fail++; $display("BAD %0t got %0h want %0h", $time, a, b); end end
module test_pic_ctrl
  import pic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Short crystal wait keeps the run brief
  localparam int XT = 20;
  logic ref_clk, rst_b, ext_int_b, level_int_0, level_int_1, edge_int;
  logic serial1_is_flags, ext_int_a0, ext_int_a1, flag_input, flag_out_wr;
  logic flag_out_wdata, pd_enter_op, osc_stopped, powerup_context_reset_bit;
  logic mask_wr, ctrl_wr, fc_wr, global_int_enable_op, global_int_disable_op;
  logic int_ack, int_rti, loop_push, loop_pop, ms_wr, idle_op, slow_idle_en;
  logic boot_cfg, bus_req_pending, boot_done, long_pulse;
  logic [1:0] slow_div_sel;
  logic [6:0] fire, evt;
  logic [NSRC-1:0] mask_wdata, interrupt_mask_reg, m, f, p;
  pic_ctrl_t ctrl_wdata, interrupt_control_reg;
  pic_fc_t fc_wdata;
  logic [15:0] status_in, status_out, w1, w2;
  logic [MODE_STATUS_REG_W-1:0] ms_wdata, mode_status_reg;
  logic flag_input_val, flag_output, powerdown_ack_pin, int_enabled, int_req;
  logic stack_overflow, stack_underflow, core_idle, core_tick, boot_start;
  logic core_restart, core_resume;
  logic [VEC_W-1:0] int_vector, restart_vector;
  logic [SRC_W-1:0] int_src;
  int n_fail, total_checks, seed, cyc, k;

  pic_src_mdl pic_src_mdl_i (.ref_clk, .rst_b, .fire, .long_pulse, .evt);
  pic_ctrl #(.PD_XTAL_CYCLES(XT)) pic_ctrl_i (.ref_clk, .rst_b, .ext_int_b,
    .level_int_0, .level_int_1, .edge_int, .serial1_is_flags, .ext_int_a0,
    .ext_int_a1, .flag_input, .flag_input_val, .flag_out_wr, .flag_out_wdata,
    .flag_output, .serial0_tx_evt(evt[0]), .serial0_rx_evt(evt[1]),
    .serial1_tx_evt(evt[2]), .serial1_rx_evt(evt[3]), .byte_dma_evt(evt[4]),
    .timer_evt(evt[5]), .powerdown_request_pin(evt[6]), .powerdown_ack_pin,
    .pd_enter_op, .osc_stopped, .powerup_context_reset_bit, .mask_wr,
    .mask_wdata, .interrupt_mask_reg, .ctrl_wr, .ctrl_wdata,
    .interrupt_control_reg, .fc_wr, .fc_wdata, .global_int_enable_op,
    .global_int_disable_op, .int_enabled, .int_req, .int_vector, .int_src,
    .int_ack, .int_rti, .loop_push, .loop_pop, .status_in, .status_out,
    .stack_overflow, .stack_underflow, .ms_wr, .ms_wdata, .mode_status_reg,
    .idle_op, .slow_idle_en, .slow_div_sel, .core_idle, .core_tick,
    .boot_cfg, .bus_req_pending, .boot_done, .boot_start, .core_restart,
    .core_resume, .restart_vector);

  always #10 ref_clk = ~ref_clk;

  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  function automatic logic [VEC_W-1:0] vec_of(logic [SRC_W-1:0] s);
    return (s == 4'h0) ? 14'h002C : {8'h00, s, 2'h0};
  endfunction
  function automatic logic [SRC_W-1:0] top(logic [NSRC-1:0] q);
    for (int i = NSRC - 1; i >= 0; i--) if (q[i]) top = SRC_W'(i);
  endfunction

  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic see(ref logic s, input int n);
    int j;
    j = 0;
    while (s !== 1'h1 && j < n) begin step(); j++; end
    `CHK(s, 1'h1)
  endtask
  task automatic quiet(int n);
    repeat (n) begin step(); `CHK(int_req, 1'h0) end
  endtask
  task automatic hit(ref logic s);
    s = 1'h1;
    step();
    s = 1'h0;
  endtask
  task automatic kick(int i);
    fire[i] = 1'h1;
    step();
    fire[i] = 1'h0;
  endtask
  task automatic fc(logic [NSRC-1:0] fb, logic [NSRC-1:0] cb);
    fc_wdata = {fb, cb};
    hit(fc_wr);
  endtask
  task automatic set_mask(logic [NSRC-1:0] v);
    mask_wdata = v;
    hit(mask_wr);
  endtask
  task automatic set_ctrl(pic_ctrl_t v);
    ctrl_wdata = v;
    hit(ctrl_wr);
  endtask
  task automatic take(logic [SRC_W-1:0] s, output logic [15:0] w);
    w = 16'($random(seed));
    see(int_req, 8);
    `CHK(int_src, s)
    `CHK(int_vector, vec_of(s))
    status_in = w;
    hit(int_ack);
    `CHK(int_req, 1'h0)
  endtask
  task automatic ret(logic [15:0] w);
    hit(int_rti);
    step();
    `CHK(status_out, w)
  endtask
  task automatic serve(logic [SRC_W-1:0] s);
    logic [15:0] w;
    take(s, w);
    ret(w);
  endtask
  task automatic wake(int a, ref logic done);
    int j;
    j = 0;
    kick(6);
    while (powerdown_ack_pin !== 1'h0 && j < 8) begin step(); j++; end
    j = 0;
    while (done !== 1'h1 && j < a + 40) begin step(); j++; end
    `CHK(j, a)
  endtask
  task automatic do_reset(logic boot);
    rst_b = 1'h0;
    boot_cfg = boot;
    bus_req_pending = 1'h1;
    step(5);
    rst_b = 1'h1;
    step(3);
    `CHK({boot_start, core_restart}, 2'h0)
    `CHK(interrupt_mask_reg, 11'h000)
    `CHK(mode_status_reg, 7'h00)
    `CHK({int_enabled, powerdown_ack_pin, stack_overflow}, 3'h4)
    `CHK({stack_underflow, int_req, core_idle}, 3'h0)
    bus_req_pending = 1'h0;
    if (boot) begin
      see(boot_start, 4);
      hit(boot_done);
    end else begin
      see(core_restart, 4);
      `CHK(restart_vector, 14'h0000)
    end
  endtask

  initial begin
    {ref_clk, rst_b, ext_int_b, level_int_0, level_int_1, edge_int,
      serial1_is_flags, ext_int_a0, ext_int_a1, flag_input, flag_out_wr,
      flag_out_wdata, pd_enter_op, osc_stopped, powerup_context_reset_bit,
      mask_wr, ctrl_wr, fc_wr, global_int_enable_op, global_int_disable_op,
      int_ack, int_rti, loop_push, loop_pop, ms_wr, idle_op, slow_idle_en,
      boot_cfg, bus_req_pending, boot_done, long_pulse, slow_div_sel, fire,
      mask_wdata, ctrl_wdata, fc_wdata, status_in, ms_wdata} = '0;
    seed = 70;
    n_fail = 0;
    total_checks = 0;
    cyc = 0;
    do_reset(1'h1);
    hit(loop_pop);
    step();
    `CHK(stack_underflow, 1'h1)
    fc(11'h7FE, 11'h000);
    quiet(4);
    set_mask(11'h7FE);
    for (int i = 1; i < NSRC; i++) serve(SRC_W'(i));
    repeat (6) begin
      m = 11'($random(seed)) & 11'h7FE;
      f = 11'($random(seed)) & 11'h7FE;
      set_mask(m);
      fc(f, 11'h000);
      p = m & f;
      while (p != 11'h000) begin
        serve(top(p));
        p = p & ~(11'h001 << top(p));
      end
      quiet(3);
      fc(11'h000, 11'h7FF);
    end
    set_mask(11'h7FE);
    long_pulse = 1'h1;
    fire = 7'h20;
    step();
    fire = 7'h1F;
    step();
    fire = 7'h00;
    long_pulse = 1'h0;
    // The timer edge lands a cycle early, so it is offered first
    for (int i = 0; i < 6; i++) begin
      serve(SRC_W'(i == 0 ? 10 : (i > 2 ? i + 4 : i + 3)));
    end
    quiet(4);
    level_int_0 = 1'h1;
    see(int_req, 6);
    `CHK(int_src, 4'h3)
    level_int_0 = 1'h0;
    quiet(3);
    hit(edge_int);
    see(int_req, 6);
    fc(11'h000, 11'h040);
    step(2);
    `CHK(int_req, 1'h0)
    hit(ext_int_b);
    step(3);
    `CHK(int_req, 1'h0)
    set_ctrl(4'h4);
    `CHK(interrupt_control_reg, 4'h4)
    hit(ext_int_b);
    serve(4'h1);
    serial1_is_flags = 1'h1;
    ext_int_a0 = 1'h1;
    take(4'h9, w1);
    ext_int_a0 = 1'h0;
    ret(w1);
    set_ctrl(4'h2);
    hit(ext_int_a1);
    serve(4'h8);
    flag_input = 1'h1;
    flag_out_wdata = 1'h1;
    hit(flag_out_wr);
    step();
    `CHK({flag_input_val, flag_output}, 2'h3)
    serial1_is_flags = 1'h0;
    set_mask(11'h400);
    fc(11'h400, 11'h000);
    see(int_req, 6);
    set_mask(11'h400);
    `CHK(int_req, 1'h0)
    serve(4'hA);
    set_mask(11'h7FE);
    set_ctrl(4'h8);
    fc(11'h040, 11'h000);
    take(4'h6, w1);
    fc(11'h002, 11'h000);
    take(4'h1, w2);
    ret(w2);
    ret(w1);
    set_ctrl(4'h0);
    fc(11'h040, 11'h000);
    take(4'h6, w1);
    fc(11'h002, 11'h000);
    quiet(4);
    ret(w1);
    serve(4'h1);
    set_mask(11'h400);
    for (int s = 0; s < 4; s++) begin
      slow_div_sel = 2'(s);
      slow_idle_en = 1'h1;
      hit(idle_op);
      `CHK(core_idle, 1'h1)
      k = 0;
      repeat (32 << s) begin k += int'(core_tick === 1'h1); step(); end
      `CHK(k, 2)
      fc(11'h400, 11'h000);
      step(2);
      `CHK(core_idle, 1'h0)
      serve(4'hA);
    end
    set_mask(11'h000);
    hit(global_int_disable_op);
    `CHK(int_enabled, 1'h0)
    fc(11'h001, 11'h000);
    quiet(5);
    hit(global_int_enable_op);
    serve(4'h0);
    hit(pd_enter_op);
    `CHK(powerdown_ack_pin, 1'h1)
    wake(PD_FAST_CYC, core_resume);
    kick(6);
    serve(4'h0);
    hit(pd_enter_op);
    `CHK(powerdown_ack_pin, 1'h1)
    osc_stopped = 1'h1;
    powerup_context_reset_bit = 1'h1;
    wake(XT, core_restart);
    loop_push = 1'h1;
    step(12);
    `CHK(stack_overflow, 1'h0)
    step();
    loop_push = 1'h0;
    `CHK(stack_overflow, 1'h1)
    ms_wdata = 7'h55;
    hit(ms_wr);
    fc(11'h001, 11'h000);
    take(4'h0, w1);
    hit(pd_enter_op);
    do_reset(1'h0);
    end_sim();
  end
endmodule // test_pic_ctrl
`default_nettype wire
